/* logic/pmbc_pkg.sv */
// constants shared by the per-port basic control register bank
package pmbc_pkg;
  localparam int unsigned NUM_PORTS     = 5;
  localparam logic [4:0]  PHY_ADDR_FIRST = 5'h01;
  localparam logic [4:0]  PHY_ADDR_LAST  = 5'h05;
  localparam logic [4:0]  REG_BASIC_CTRL = 5'h00;

  // field positions of the basic control word
  localparam int unsigned BIT_SOFT_RESET    = 15;
  localparam int unsigned BIT_MAC_LOOPBACK  = 14;
  localparam int unsigned BIT_SPEED_100     = 13;
  localparam int unsigned BIT_NEG_ENABLE    = 12;
  localparam int unsigned BIT_POWER_DOWN    = 11;
  localparam int unsigned BIT_LINE_ISOLATE  = 10;
  localparam int unsigned BIT_NEG_RESTART   = 9;
  localparam int unsigned BIT_FULL_DUPLEX   = 8;
  localparam int unsigned BIT_XOVER_ALGO    = 5;
  localparam int unsigned BIT_FORCE_STRAIGHT = 4;
  localparam int unsigned BIT_XOVER_DISABLE = 3;
  localparam int unsigned BIT_FAR_FAULT_DIS = 2;
  localparam int unsigned BIT_TX_DISABLE    = 1;
  localparam int unsigned BIT_LED_DISABLE   = 0;

  // reset value: speed 100, negotiation on, standard crossover variant
  localparam logic [15:0] CTRL_RESET      = 16'h3020;
  // storable bits; 15 and 9 are self-clearing, 7 and 6 read zero
  localparam logic [15:0] CTRL_STORE_MASK = 16'h7d3f;

  // management frame layout
  localparam logic [5:0]  PREAMBLE_ONES = 6'h20;
  localparam logic [5:0]  HDR_BITS_LAST = 6'h0b;
  localparam logic [5:0]  DATA_BITS_LAST = 6'h0f;
  localparam logic [1:0]  OP_WRITE      = 2'h1;
  localparam logic [1:0]  OP_READ       = 2'h2;

  typedef enum logic [2:0] {
    MF_IDLE,
    MF_START,
    MF_HDR,
    MF_TURN,
    MF_DATA
  } pmbc_frame_t;
endpackage

/* logic/pmbc_mgmt_frame.sv */
// serial management frame slave: decodes clause-22 frames into register accesses
`timescale 1ns/1ns
module pmbc_mgmt_frame (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  input  wire logic        mdc,
  input  wire logic        mdio_in,
  output logic             mdio_out,
  output logic             mdio_oe,
  output logic [4:0]       acc_phy,
  output logic [4:0]       acc_reg,
  output logic [15:0]      acc_wdata,
  output logic             acc_wr,
  input  wire logic [15:0] acc_rdata
);
  import pmbc_pkg::*;

  pmbc_frame_t state_ff, nxt_state;
  logic [5:0]  cnt_ff, nxt_cnt;
  logic [15:0] sh_ff, nxt_sh;
  logic [1:0]  op_ff, nxt_op;
  logic        mdc_ff;
  logic [4:0]  phy_ff, nxt_phy, reg_ff, nxt_reg;
  logic [15:0] wd_ff, nxt_wd;
  logic        wr_ff, nxt_wr, out_ff, nxt_out, oe_ff, nxt_oe;
  logic        rise;

  // mdc is synchronous to ref_clk, so one register suffices for the edge
  assign rise = mdc & ~mdc_ff;

  // frame walk: bits are sampled and driven on the mdc rising edge
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_sh    = sh_ff;
    nxt_op    = op_ff;
    nxt_phy   = phy_ff;
    nxt_reg   = reg_ff;
    nxt_wd    = wd_ff;
    nxt_wr    = 1'b0;
    nxt_out   = out_ff;
    nxt_oe    = oe_ff;
    if (rise) begin
      case (state_ff)
        MF_IDLE: begin
          if (mdio_in) begin
            if (cnt_ff < PREAMBLE_ONES) nxt_cnt = cnt_ff + 6'h01;
          end else if (cnt_ff == PREAMBLE_ONES) begin
            nxt_state = MF_START;
          end else begin
            nxt_cnt = 6'h00;
          end
        end
        MF_START: begin
          nxt_cnt   = 6'h00;
          nxt_state = mdio_in ? MF_HDR : MF_IDLE;
        end
        MF_HDR: begin
          nxt_sh  = {sh_ff[14:0], mdio_in};
          nxt_cnt = cnt_ff + 6'h01;
          if (cnt_ff == HDR_BITS_LAST) begin
            nxt_op  = sh_ff[10:9];
            nxt_phy = sh_ff[8:4];
            nxt_reg = {sh_ff[3:0], mdio_in};
            nxt_cnt = 6'h00;
            nxt_state = (sh_ff[10:9] == OP_READ || sh_ff[10:9] == OP_WRITE) ? MF_TURN : MF_IDLE;
          end
        end
        MF_TURN: begin
          nxt_cnt = cnt_ff + 6'h01;
          if (cnt_ff == 6'h00) begin
            if (op_ff == OP_READ) begin
              nxt_oe  = 1'b1; // second turnaround bit driven low
              nxt_out = 1'b0;
              nxt_sh  = acc_rdata;
            end
          end else begin
            if (op_ff == OP_READ) begin
              nxt_out = sh_ff[15];
              nxt_sh  = {sh_ff[14:0], 1'b0};
            end
            nxt_cnt   = 6'h00;
            nxt_state = MF_DATA;
          end
        end
        MF_DATA: begin
          nxt_cnt = cnt_ff + 6'h01;
          if (op_ff == OP_READ) begin
            nxt_out = sh_ff[15];
            nxt_sh  = {sh_ff[14:0], 1'b0};
          end else begin
            nxt_sh = {sh_ff[14:0], mdio_in};
          end
          if (cnt_ff == DATA_BITS_LAST) begin
            nxt_oe    = 1'b0;
            nxt_out   = 1'b0;
            nxt_cnt   = 6'h00;
            nxt_state = MF_IDLE;
            if (op_ff == OP_WRITE) begin
              nxt_wd = {sh_ff[14:0], mdio_in};
              nxt_wr = 1'b1;
            end
          end
        end
        default: begin
          nxt_state = MF_IDLE;
          nxt_cnt   = 6'h00;
          nxt_oe    = 1'b0;
        end
      endcase
    end
  end

  // registers; clock enable low freezes everything
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_ff <= MF_IDLE;
      cnt_ff   <= 6'h00;
      sh_ff    <= 16'h0000;
      op_ff    <= 2'h0;
      phy_ff   <= 5'h00;
      reg_ff   <= 5'h00;
      wd_ff    <= 16'h0000;
      wr_ff    <= 1'b0;
      out_ff   <= 1'b0;
      oe_ff    <= 1'b0;
      mdc_ff   <= 1'b0;
    end else if (clk_en) begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      sh_ff    <= nxt_sh;
      op_ff    <= nxt_op;
      phy_ff   <= nxt_phy;
      reg_ff   <= nxt_reg;
      wd_ff    <= nxt_wd;
      wr_ff    <= nxt_wr;
      out_ff   <= nxt_out;
      oe_ff    <= nxt_oe;
      mdc_ff   <= mdc;
    end
  end

  assign mdio_out  = out_ff;
  assign mdio_oe   = oe_ff;
  assign acc_phy   = phy_ff;
  assign acc_reg   = reg_ff;
  assign acc_wdata = wd_ff;
  assign acc_wr    = wr_ff;
endmodule // pmbc_mgmt_frame

/* logic/pmbc_top.sv */
// per-port phy basic control register bank with management frame and host port access
// Behaviour
// - phy addresses 1 to 5 select ports 1 to 5 in management frames
// - within a port, only register address 0, the basic control word, forms the map
// - the control word is also reachable from the host port, same port and register mapping
// - bit 15 soft-resets the port, self-clears, reads zero
// - bit 14 turns on mac loopback for that port, default 0
// - bit 13 selects forced speed, 1 is 100 and 0 is 10, resets 1
// - bit 12 enables auto-negotiation, resets to 1
// - bit 11 powers the port's phy down, resets 0
// - bit 10 isolates the phy from its transmit pair, resets 0
// - writing 1 to bit 9 restarts auto-negotiation, resets 0
// - bit 8 selects forced duplex, 1 full and 0 half, resets 0
// - bit 5 picks crossover algorithm, 1 standard, 0 own, resets 1
// - bit 4 forces straight pair usage, resets 0
// - bit 3 disables automatic crossover, resets 0
// - bits 2,1,0 disable far-end fault, transmitter and leds, reset 0
`timescale 1ns/1ns
module pmbc_top (
  input  wire logic                            ref_clk,
  input  wire logic                            sys_rst,
  input  wire logic                            clk_en,
  input  wire logic                            mdc,
  input  wire logic                            mdio_in,
  output logic                                 mdio_out,
  output logic                                 mdio_oe,
  input  wire logic                            host_sel,
  input  wire logic                            host_wr,
  input  wire logic [4:0]                      host_port,
  input  wire logic [4:0]                      host_reg,
  input  wire logic [15:0]                     host_wdata,
  output logic [15:0]                          host_rdata,
  output logic                                 host_ready,
  output logic [pmbc_pkg::NUM_PORTS-1:0]       phy_soft_reset,
  output logic [pmbc_pkg::NUM_PORTS-1:0]       mac_loopback,
  output logic [pmbc_pkg::NUM_PORTS-1:0]       speed_100,
  output logic [pmbc_pkg::NUM_PORTS-1:0]       negotiation_enable,
  output logic [pmbc_pkg::NUM_PORTS-1:0]       power_down,
  output logic [pmbc_pkg::NUM_PORTS-1:0]       line_isolate,
  output logic [pmbc_pkg::NUM_PORTS-1:0]       negotiation_restart,
  output logic [pmbc_pkg::NUM_PORTS-1:0]       full_duplex,
  output logic [pmbc_pkg::NUM_PORTS-1:0]       crossover_algorithm_select,
  output logic [pmbc_pkg::NUM_PORTS-1:0]       force_straight_pairs,
  output logic [pmbc_pkg::NUM_PORTS-1:0]       auto_crossover_disable,
  output logic [pmbc_pkg::NUM_PORTS-1:0]       far_fault_disable,
  output logic [pmbc_pkg::NUM_PORTS-1:0]       transmit_disable,
  output logic [pmbc_pkg::NUM_PORTS-1:0]       led_disable
);
  import pmbc_pkg::*;

  logic [15:0]          ctrl_ff [NUM_PORTS];
  logic [15:0]          nxt_ctrl [NUM_PORTS];
  logic [NUM_PORTS-1:0] srst_ff, nxt_srst, rstrt_ff, nxt_rstrt;
  logic [15:0]          hrd_ff, nxt_hrd;
  logic [4:0]           mf_phy, mf_reg;
  logic [15:0]          mf_wdata;
  logic                 mf_wr;
  logic [15:0]          mf_rdata;

  // port index from a phy address; ports 1..5 map to index 0..4
  function automatic logic [2:0] port_idx(input logic [4:0] phy);
    logic [4:0] d;
    d = phy - PHY_ADDR_FIRST;
    return d[2:0];
  endfunction

  // true when the address pair hits a stored control word
  function automatic logic hits_ctrl(input logic [4:0] phy, input logic [4:0] regad);
    return (phy >= PHY_ADDR_FIRST) && (phy <= PHY_ADDR_LAST)
        && (regad == REG_BASIC_CTRL);
  endfunction

  // read value; everything outside the control word reads zero here
  function automatic logic [15:0] read_word(input logic [4:0] phy, input logic [4:0] regad,
                                            input logic [15:0] cw [NUM_PORTS]);
    logic [15:0] v;
    v = 16'h0000;
    if (hits_ctrl(phy, regad)) v = cw[port_idx(phy)] & CTRL_STORE_MASK;
    return v;
  endfunction

  pmbc_mgmt_frame pmbc_mgmt_frame_i (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .clk_en    (clk_en),
    .mdc       (mdc),
    .mdio_in   (mdio_in),
    .mdio_out  (mdio_out),
    .mdio_oe   (mdio_oe),
    .acc_phy   (mf_phy),
    .acc_reg   (mf_reg),
    .acc_wdata (mf_wdata),
    .acc_wr    (mf_wr),
    .acc_rdata (mf_rdata)
  );

  // frame read data; the slave latches it in the turnaround
  assign mf_rdata = read_word(mf_phy, mf_reg, ctrl_ff);

  // host port is stalled only while a frame write lands in the same cycle
  assign host_ready = ~mf_wr;

  // write merge: frame write first, host write when no frame write is due
  always_comb begin
    logic [4:0]  wphy;
    logic [4:0]  wreg;
    logic [15:0] wdat;
    logic        wen;
    logic [2:0]  p;
    wphy = mf_wr ? mf_phy : host_port;
    wreg = mf_wr ? mf_reg : host_reg;
    wdat = mf_wr ? mf_wdata : host_wdata;
    wen  = mf_wr | (host_sel & host_wr);
    p    = port_idx(wphy);
    nxt_srst  = '0;
    nxt_rstrt = '0;
    for (int i = 0; i < NUM_PORTS; i++) begin
      nxt_ctrl[i] = ctrl_ff[i];
    end
    if (wen && hits_ctrl(wphy, wreg)) begin
      if (wdat[BIT_SOFT_RESET]) begin
        nxt_ctrl[p] = CTRL_RESET;
        nxt_srst[p] = 1'b1;
      end else begin
        nxt_ctrl[p]  = wdat & CTRL_STORE_MASK;
        nxt_rstrt[p] = wdat[BIT_NEG_RESTART];
      end
    end
  end

  // host read data is registered, valid the cycle after a select
  always_comb begin
    nxt_hrd = hrd_ff;
    if (host_sel && !host_wr) nxt_hrd = read_word(host_port, host_reg, ctrl_ff);
  end

  // control state; clock enable low holds it
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < NUM_PORTS; i++) begin
        ctrl_ff[i] <= CTRL_RESET;
      end
      srst_ff  <= '0;
      rstrt_ff <= '0;
      hrd_ff   <= 16'h0000;
    end else if (clk_en) begin
      for (int i = 0; i < NUM_PORTS; i++) begin
        ctrl_ff[i] <= nxt_ctrl[i];
      end
      srst_ff  <= nxt_srst;
      rstrt_ff <= nxt_rstrt;
      hrd_ff   <= nxt_hrd;
    end
  end

  // per-port field fan-out, each bit straight from its flip-flop
  always_comb begin
    for (int i = 0; i < NUM_PORTS; i++) begin
      mac_loopback[i]               = ctrl_ff[i][BIT_MAC_LOOPBACK];
      speed_100[i]                  = ctrl_ff[i][BIT_SPEED_100];
      negotiation_enable[i]         = ctrl_ff[i][BIT_NEG_ENABLE];
      power_down[i]                 = ctrl_ff[i][BIT_POWER_DOWN];
      line_isolate[i]               = ctrl_ff[i][BIT_LINE_ISOLATE];
      full_duplex[i]                = ctrl_ff[i][BIT_FULL_DUPLEX];
      crossover_algorithm_select[i] = ctrl_ff[i][BIT_XOVER_ALGO];
      force_straight_pairs[i]       = ctrl_ff[i][BIT_FORCE_STRAIGHT];
      auto_crossover_disable[i]     = ctrl_ff[i][BIT_XOVER_DISABLE];
      far_fault_disable[i]          = ctrl_ff[i][BIT_FAR_FAULT_DIS];
      transmit_disable[i]           = ctrl_ff[i][BIT_TX_DISABLE];
      led_disable[i]                = ctrl_ff[i][BIT_LED_DISABLE];
    end
  end

  assign phy_soft_reset      = srst_ff;
  assign negotiation_restart = rstrt_ff;
  assign host_rdata          = hrd_ff;
endmodule // pmbc_top

/* dv/pmbc_top_asserts.sv */
// concurrent checks on the host port and control outputs of the bank
`timescale 1ns/1ns
module pmbc_top_asserts (
  input wire logic                          ref_clk,
  input wire logic                          sys_rst,
  input wire logic                          clk_en,
  input wire logic                          host_sel,
  input wire logic                          host_wr,
  input wire logic [4:0]                    host_port,
  input wire logic [4:0]                    host_reg,
  input wire logic [15:0]                   host_wdata,
  input wire logic [15:0]                   host_rdata,
  input wire logic                          host_ready,
  input wire logic [pmbc_pkg::NUM_PORTS-1:0] phy_soft_reset,
  input wire logic [pmbc_pkg::NUM_PORTS-1:0] mac_loopback,
  input wire logic [pmbc_pkg::NUM_PORTS-1:0] speed_100,
  input wire logic [pmbc_pkg::NUM_PORTS-1:0] negotiation_enable,
  input wire logic [pmbc_pkg::NUM_PORTS-1:0] power_down,
  input wire logic [pmbc_pkg::NUM_PORTS-1:0] negotiation_restart,
  input wire logic [pmbc_pkg::NUM_PORTS-1:0] full_duplex,
  input wire logic [pmbc_pkg::NUM_PORTS-1:0] crossover_algorithm_select
);
  import pmbc_pkg::*;
  logic [NUM_PORTS-1:0] hot;
  logic                 bad;
  logic                 wr_ok;
  logic                 rd_ok;
  // one-hot of the addressed port, zero when the address is outside 1..5
  always_comb begin
    hot = 5'h00;
    if (host_port >= 5'h01 && host_port <= 5'h05) hot = 5'h01 << (host_port - 5'h01);
  end
  assign bad   = (host_reg != 5'h00) || (hot == 5'h00);
  // ready guards against a frame write landing in the same cycle
  assign wr_ok = clk_en && host_sel && host_wr && host_ready && !bad;
  assign rd_ok = clk_en && host_sel && !host_wr && host_ready && !bad;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  reset_values_a: assert property ($fell(sys_rst) |-> speed_100 == 5'h1f &&
    negotiation_enable == 5'h1f && crossover_algorithm_select == 5'h1f && mac_loopback == 5'h00)
    else $error("control outputs not at reset values");
  soft_reset_pulse_a: assert property (wr_ok && host_wdata[15] |=>
    phy_soft_reset == $past(hot) && (speed_100 & $past(hot)) == $past(hot))
    else $error("soft reset pulse or restore wrong");
  restart_pulse_a: assert property (wr_ok && host_wdata[9] && !host_wdata[15] |=>
    negotiation_restart == $past(hot)) else $error("restart pulse wrong");
  restart_quiet_a: assert property (wr_ok && !host_wdata[9] |=>
    (negotiation_restart & $past(hot)) == 5'h00) else $error("restart pulse without cause");
  loopback_write_a: assert property (wr_ok && !host_wdata[15] |=>
    ((mac_loopback ^ {NUM_PORTS{$past(host_wdata[14])}}) & $past(hot)) == 5'h00)
    else $error("loopback output not written");
  speed_write_a: assert property (wr_ok && !host_wdata[15] |=>
    ((speed_100 ^ {NUM_PORTS{$past(host_wdata[13])}}) & $past(hot)) == 5'h00)
    else $error("speed output not written");
  power_write_a: assert property (wr_ok && !host_wdata[15] |=>
    ((power_down ^ {NUM_PORTS{$past(host_wdata[11])}}) & $past(hot)) == 5'h00)
    else $error("power down output not written");
  duplex_write_a: assert property (wr_ok && !host_wdata[15] |=>
    ((full_duplex ^ {NUM_PORTS{$past(host_wdata[8])}}) & $past(hot)) == 5'h00)
    else $error("duplex output not written");
  read_fields_a: assert property (rd_ok |=> host_rdata[15] == 1'b0 && host_rdata[9] == 1'b0
    && host_rdata[7:6] == 2'b00 && host_rdata[13] == |($past(speed_100) & $past(hot)))
    else $error("read word fields wrong");
  bad_read_zero_a: assert property (clk_en && host_sel && !host_wr && bad |=>
    host_rdata == 16'h0000) else $error("bad address read not zero");
  bad_write_hold_a: assert property (clk_en && host_sel && host_wr && host_ready && bad |=>
    $stable(mac_loopback) && $stable(speed_100) && $stable(power_down) && phy_soft_reset == 5'h00)
    else $error("bad address write changed state");
endmodule // pmbc_top_asserts

/* dv/pmbc_station.sv */
// station manager model: drives management frames on mdc and mdio
`timescale 1ns/1ns
module pmbc_station #(
  parameter int HALF = 2
) (
  input wire logic ref_clk,
  input wire logic mdio,
  output logic     mdc,
  output logic     st_out,
  output logic     st_oe
);
  // mdc stands low outside frames
  initial begin
    mdc    = 1'b0;
    st_out = 1'b1;
    st_oe  = 1'b0;
  end
  // one whole frame; data changes while mdc is low, read bits taken just before the rise
  task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] rg,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [63:0] bits;
    bits = {32'hffff_ffff, 2'b01, op, phy, rg, 2'b10, wd};
    rd = 16'h0000;
    for (int i = 0; i < 64; i++) begin
      repeat (HALF) @(posedge ref_clk);
      #1;
      mdc    = 1'b0;
      st_oe  = !(op == 2'b10 && i >= 46); // released from turnaround on a read
      st_out = bits[63-i];
      repeat (HALF) @(posedge ref_clk);
      #1;
      if (i >= 48) rd = {rd[14:0], mdio};
      mdc = 1'b1;
    end
    repeat (HALF) @(posedge ref_clk);
    #1;
    mdc   = 1'b0;
    st_oe = 1'b0;
    repeat (4 * HALF) @(posedge ref_clk); // lets a write commit
  endtask
endmodule // pmbc_station

/* dv/pmbc_tb_top.sv */
// testbench for the basic control register bank
`timescale 1ns/1ns
module pmbc_tb_top;
  import pmbc_pkg::*;
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        clk_en = 1'b1;
  logic        host_sel = 1'b0;
  logic        host_wr = 1'b0;
  logic [4:0]  host_port = 5'h00;
  logic [4:0]  host_reg = 5'h00;
  logic [15:0] host_wdata = 16'h0000;
  wire  [15:0] host_rdata;
  wire         host_ready, mdc, mdio_out, mdio_oe, st_out, st_oe, mdio;
  wire  [4:0]  phy_soft_reset, mac_loopback, speed_100, negotiation_enable, power_down;
  wire  [4:0]  line_isolate, negotiation_restart, full_duplex, crossover_algorithm_select;
  wire  [4:0]  force_straight_pairs, auto_crossover_disable, far_fault_disable;
  wire  [4:0]  transmit_disable, led_disable;
  int          n_errors = 0;
  int          n_compared = 0;
  int          cycles = 0;
  logic [15:0] rd;
  localparam logic [15:0] ONE [12] = '{16'h4000, 16'h2000, 16'h1000, 16'h0800, 16'h0400,
    16'h0100, 16'h0020, 16'h0010, 16'h0008, 16'h0004, 16'h0002, 16'h0001};
  localparam logic [9:0] BAD [6] = '{10'h000, 10'h0c0, 10'h021, 10'h03d, 10'h03f, 10'h3e0};
  // pull-up when nobody drives the data line
  assign mdio = mdio_oe ? mdio_out : (st_oe ? st_out : 1'b1);
  always #10 ref_clk = ~ref_clk;

  pmbc_top pmbc_top_i (.ref_clk, .sys_rst, .clk_en, .mdc, .mdio_in(mdio), .mdio_out, .mdio_oe,
    .host_sel, .host_wr, .host_port, .host_reg, .host_wdata, .host_rdata, .host_ready,
    .phy_soft_reset, .mac_loopback, .speed_100, .negotiation_enable, .power_down, .line_isolate,
    .negotiation_restart, .full_duplex, .crossover_algorithm_select, .force_straight_pairs,
    .auto_crossover_disable, .far_fault_disable, .transmit_disable, .led_disable);
  pmbc_station pmbc_station_i (.ref_clk, .mdio, .mdc, .st_out, .st_oe);

  task automatic results;
    if (n_errors == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one host access, held until ready stands high at the taking edge
  task automatic hacc(input logic wr, input logic [4:0] p, input logic [4:0] r,
                      input logic [15:0] d);
    @(posedge ref_clk);
    #1;
    {host_sel, host_wr, host_port, host_reg, host_wdata} = {1'b1, wr, p, r, d};
    @(negedge ref_clk);
    while (!host_ready) @(negedge ref_clk);
    @(posedge ref_clk);
    #1;
    host_sel = 1'b0;
  endtask
  task automatic hchk(input logic [4:0] p, input logic [4:0] r, input logic [15:0] exp);
    hacc(1'b0, p, r, 16'h0000);
    chk("host_rdata", exp, host_rdata);
  endtask
  // control word rebuilt from the level outputs of one port
  function automatic logic [15:0] outw(input int p);
    return {1'b0, mac_loopback[p], speed_100[p], negotiation_enable[p], power_down[p],
      line_isolate[p], 1'b0, full_duplex[p], 2'b00, crossover_algorithm_select[p],
      force_straight_pairs[p], auto_crossover_disable[p], far_fault_disable[p],
      transmit_disable[p], led_disable[p]};
  endfunction

  task automatic t_reset;
    chk("host_ready", 16'h0001, {15'h0000, host_ready});
    for (int p = 0; p < 5; p++) begin
      chk("outputs", 16'h3020, outw(p));
      hchk(5'(p + 1), 5'h00, 16'h3020);
    end
  endtask
  task automatic t_fields;
    for (int i = 0; i < 12; i++) begin
      hacc(1'b1, 5'h03, 5'h00, ONE[i]);
      chk("outputs", ONE[i], outw(2));
      hchk(5'h03, 5'h00, ONE[i]);
    end
    hacc(1'b1, 5'h03, 5'h00, 16'h7dff);
    hchk(5'h03, 5'h00, 16'h7d3f);
  endtask
  task automatic t_ports;
    for (int p = 1; p <= 5; p++) hacc(1'b1, 5'(p), 5'h00, 16'h0001 << (p - 1));
    for (int p = 1; p <= 5; p++) hchk(5'(p), 5'h00, 16'h0001 << (p - 1));
  endtask
  task automatic t_soft;
    hacc(1'b1, 5'h02, 5'h00, 16'h0f11);
    hacc(1'b1, 5'h02, 5'h00, 16'h8100);
    chk("phy_soft_reset", 16'h0002, {11'h000, phy_soft_reset});
    hchk(5'h02, 5'h00, 16'h3020);
    chk("phy_soft_reset", 16'h0000, {11'h000, phy_soft_reset});
  endtask
  task automatic t_restart;
    hacc(1'b1, 5'h04, 5'h00, 16'h1200);
    chk("negotiation_restart", 16'h0008, {11'h000, negotiation_restart});
    hchk(5'h04, 5'h00, 16'h1000);
    chk("negotiation_restart", 16'h0000, {11'h000, negotiation_restart});
  endtask
  task automatic t_bad;
    hacc(1'b1, 5'h01, 5'h00, 16'h0a05);
    for (int i = 0; i < 6; i++) begin
      hacc(1'b1, BAD[i][9:5], BAD[i][4:0], 16'hffff);
      hchk(BAD[i][9:5], BAD[i][4:0], 16'h0000);
    end
    hchk(5'h01, 5'h00, 16'h0805);
  endtask
  // clock enable low drops a write; a mid-run reset restores the word
  task automatic t_hold;
    @(posedge ref_clk);
    #1;
    clk_en = 1'b0;
    hacc(1'b1, 5'h01, 5'h00, 16'h4000);
    clk_en = 1'b1;
    hchk(5'h01, 5'h00, 16'h0805);
    chk("mac_loopback", 16'h0000, {11'h000, mac_loopback});
    sys_rst = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    sys_rst = 1'b0;
    chk("outputs", 16'h3020, outw(0));
    hchk(5'h01, 5'h00, 16'h3020);
  endtask
  task automatic t_frame;
    pmbc_station_i.frame(2'b01, 5'h05, 5'h00, 16'h0520, rd);
    chk("outputs", 16'h0520, outw(4));
    pmbc_station_i.frame(2'b10, 5'h05, 5'h00, 16'h0000, rd);
    chk("frame read", 16'h0520, rd);
    chk("mdio_oe", 16'h0000, {15'h0000, mdio_oe});
    hacc(1'b1, 5'h05, 5'h00, 16'h2109);
    pmbc_station_i.frame(2'b10, 5'h05, 5'h00, 16'h0000, rd);
    chk("frame read", 16'h2109, rd);
    pmbc_station_i.frame(2'b10, 5'h07, 5'h00, 16'h0000, rd);
    chk("frame read", 16'h0000, rd);
  endtask

  // cut a hang short well past the expected run length
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 40000) begin
      n_errors++;
      results();
    end
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    #1;
    sys_rst = 1'b0;
    t_reset();
    t_fields();
    t_ports();
    t_soft();
    t_restart();
    t_bad();
    t_hold();
    t_frame();
    results();
  end
endmodule // pmbc_tb_top

bind pmbc_top pmbc_top_asserts pmbc_top_asserts_i (.ref_clk, .sys_rst, .clk_en, .host_sel,
  .host_wr, .host_port, .host_reg, .host_wdata, .host_rdata, .host_ready, .phy_soft_reset,
  .mac_loopback, .speed_100, .negotiation_enable, .power_down, .negotiation_restart,
  .full_duplex, .crossover_algorithm_select);
